// *** main_nco_tuning_phase_regs.sv ***
// axi4-lite register block and phase accumulator of the main transmit oscillator
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "main_nco_consts.svh"

module main_nco_tuning_phase_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // settings held elsewhere in the unit
  input wire logic [7:0] tuning_word_low_byte,
  input wire logic [47:0] fraction_numerator,
  input wire logic [47:8] fraction_denominator_upper,
  // controls and oscillator output
  output logic tuning_load_request,
  output logic fraction_mode_enable,
  output logic main_oscillator_enable,
  output logic [15:0] oscillator_phase
);

  // =======================================================
  // declarations
  logic aw_held_reg;
  logic [9:0] aw_index_reg;
  logic w_held_reg;
  main_nco_pkg::reg_byte_t w_data_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  main_nco_pkg::rd_state_t rd_state_reg;
  main_nco_pkg::rd_state_t rd_state_next;
  logic [9:0] ar_index_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  main_nco_pkg::reg_byte_t phase_low_reg;
  main_nco_pkg::reg_byte_t phase_high_reg;
  main_nco_pkg::reg_byte_t frac_den0_reg;
  logic load_req_reg;
  logic load_req_next;
  logic frac_en_reg;
  logic osc_en_reg;

  main_nco_pkg::tuning_word_t active_tw_reg;
  main_nco_pkg::tuning_word_t acc_reg;
  main_nco_pkg::tuning_word_t acc_next;
  logic [47:0] frac_acc_reg;
  logic [47:0] frac_acc_next;
  logic [15:0] phase_out_reg;

  main_nco_pkg::reg_byte_t shadow_rd_data;
  logic [39:0] shadow_word;

  // =======================================================
  // write decode
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [9:0] tw_wr_off = aw_index_reg - `TW_BYTE1_IDX;
  wire tw_wr_hit = (aw_index_reg >= `TW_BYTE1_IDX) && (aw_index_reg <= `TW_BYTE5_IDX);
  wire phase_low_wr_hit = (aw_index_reg == `PHASE_LOW_IDX);
  wire phase_high_wr_hit = (aw_index_reg == `PHASE_HIGH_IDX);
  wire frac_den0_wr_hit = (aw_index_reg == `FRAC_DEN0_IDX);
  wire ctrl_wr_hit = (aw_index_reg == `CTRL_IDX);
  wire status_wr_hit = (aw_index_reg == `STATUS_IDX);
  wire wr_mapped = tw_wr_hit || phase_low_wr_hit || phase_high_wr_hit || frac_den0_wr_hit
                   || ctrl_wr_hit || status_wr_hit;
  wire wr_commit = do_write && w_lane_reg;
  wire tw_wr_en = wr_commit && tw_wr_hit;
  wire ctrl_wr_en = wr_commit && ctrl_wr_hit;
  wire load_set = ctrl_wr_en && w_data_reg[`CTRL_LOAD_BIT];

  // =======================================================
  // read decode
  wire [9:0] tw_rd_off = ar_index_reg - `TW_BYTE1_IDX;
  wire tw_rd_hit = (ar_index_reg >= `TW_BYTE1_IDX) && (ar_index_reg <= `TW_BYTE5_IDX);
  wire phase_low_rd_hit = (ar_index_reg == `PHASE_LOW_IDX);
  wire phase_high_rd_hit = (ar_index_reg == `PHASE_HIGH_IDX);
  wire frac_den0_rd_hit = (ar_index_reg == `FRAC_DEN0_IDX);
  wire ctrl_rd_hit = (ar_index_reg == `CTRL_IDX);
  wire status_rd_hit = (ar_index_reg == `STATUS_IDX);
  wire rd_mapped = tw_rd_hit || phase_low_rd_hit || phase_high_rd_hit || frac_den0_rd_hit
                   || ctrl_rd_hit || status_rd_hit;

  // =======================================================
  // oscillator arithmetic
  wire [47:0] frac_modulus = {fraction_denominator_upper, frac_den0_reg}; // RULE6
  wire frac_active = frac_en_reg && (frac_modulus != 48'h000000000000); // RULE6
  wire [48:0] frac_sum = {1'b0, frac_acc_reg} + {1'b0, fraction_numerator};
  wire frac_wrap = frac_active && (frac_sum >= {1'b0, frac_modulus}); // RULE2
  wire [48:0] frac_rem = frac_sum - {1'b0, frac_modulus};
  wire [15:0] phase_code = {phase_high_reg, phase_low_reg}; // RULE4

  wire main_nco_pkg::reg_byte_t ctrl_value = {5'h00, osc_en_reg, frac_en_reg, load_req_reg};
  wire main_nco_pkg::reg_byte_t status_value = {5'h00, frac_active, osc_en_reg, load_req_reg};

  wire main_nco_pkg::reg_byte_t rd_byte =
    tw_rd_hit ? shadow_rd_data :
    phase_low_rd_hit ? phase_low_reg :
    phase_high_rd_hit ? phase_high_reg :
    frac_den0_rd_hit ? frac_den0_reg :
    ctrl_rd_hit ? ctrl_value :
    status_rd_hit ? status_value :
    `BYTE_RESET;

  // =======================================================
  // handshake outputs
  assign awready = ce && !aw_held_reg && !bvalid_reg;
  assign wready = ce && !w_held_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = ce && (rd_state_reg == main_nco_pkg::RD_IDLE);
  assign rvalid = (rd_state_reg == main_nco_pkg::RD_RESP);
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  assign tuning_load_request = load_req_reg;
  assign fraction_mode_enable = frac_en_reg;
  assign main_oscillator_enable = osc_en_reg;
  assign oscillator_phase = phase_out_reg;

  // =======================================================
  // shadow storage
  tuning_shadow_mem u_shadow (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(tw_wr_en),
    .wr_sel(tw_wr_off[2:0]),
    .wr_data(w_data_reg),
    .rd_sel(tw_rd_off[2:0]),
    .rd_data(shadow_rd_data),
    .shadow_word(shadow_word)
  );

  // =======================================================
  // write address and data capture, either order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_index_reg <= 10'h000;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_index_reg <= awaddr[11:2];
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= `BYTE_RESET;
      w_lane_reg <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // =======================================================
  // write response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // =======================================================
  // settings registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_low_reg <= `BYTE_RESET;
      phase_high_reg <= `BYTE_RESET;
      frac_den0_reg <= `BYTE_RESET;
    end else if (ce && wr_commit) begin
      if (phase_low_wr_hit) begin
        phase_low_reg <= w_data_reg; // RULE4
      end
      if (phase_high_wr_hit) begin
        phase_high_reg <= w_data_reg; // RULE4
      end
      if (frac_den0_wr_hit) begin
        frac_den0_reg <= w_data_reg; // RULE6
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frac_en_reg <= `BIT_RESET;
      osc_en_reg <= `BIT_RESET;
    end else if (ce && ctrl_wr_en) begin
      frac_en_reg <= w_data_reg[`CTRL_FRAC_BIT];
      osc_en_reg <= w_data_reg[`CTRL_ENABLE_BIT]; // RULE8
    end
  end

  // =======================================================
  // load request: a 0 to 1 write arms it, the load clears it
  always_comb begin
    load_req_next = load_req_reg;
    if (load_req_reg) begin
      load_req_next = 1'b0; // RULE7
    end
    if (load_set && !load_req_reg) begin
      load_req_next = 1'b1; // RULE7
    end
    if (load_set && load_req_reg) begin
      load_req_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      load_req_reg <= `BIT_RESET;
    end else if (ce) begin
      load_req_reg <= load_req_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_tw_reg <= 48'h000000000000;
    end else if (ce && load_req_reg) begin
      active_tw_reg <= {shadow_word, tuning_word_low_byte}; // RULE3 RULE9
    end
  end

  // =======================================================
  // read channel
  always_comb begin
    rd_state_next = rd_state_reg;
    unique case (rd_state_reg)
      main_nco_pkg::RD_IDLE: begin
        if (arvalid) begin
          rd_state_next = main_nco_pkg::RD_FETCH;
        end
      end
      main_nco_pkg::RD_FETCH: begin
        rd_state_next = main_nco_pkg::RD_MUX;
      end
      main_nco_pkg::RD_MUX: begin
        rd_state_next = main_nco_pkg::RD_RESP;
      end
      main_nco_pkg::RD_RESP: begin
        if (rready) begin
          rd_state_next = main_nco_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_state_reg <= main_nco_pkg::RD_IDLE;
    end else if (ce) begin
      rd_state_reg <= rd_state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ar_index_reg <= 10'h000;
    end else if (ce && arvalid && arready) begin
      ar_index_reg <= araddr[11:2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (ce && (rd_state_reg == main_nco_pkg::RD_MUX)) begin
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // =======================================================
  // phase accumulator; one step per enabled sample clock
  always_comb begin
    acc_next = acc_reg + active_tw_reg; // RULE1
    frac_acc_next = frac_acc_reg;
    if (frac_active) begin
      frac_acc_next = frac_wrap ? frac_rem[47:0] : frac_sum[47:0]; // RULE2
      if (frac_wrap) begin
        acc_next = acc_reg + active_tw_reg + 48'h000000000001; // RULE2
      end
    end
    if (!osc_en_reg) begin
      acc_next = 48'h000000000000; // RULE8
      frac_acc_next = 48'h000000000000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_reg <= 48'h000000000000;
      frac_acc_reg <= 48'h000000000000;
    end else if (ce) begin
      acc_reg <= acc_next;
      frac_acc_reg <= frac_acc_next;
    end
  end

  // 2^16 code steps span 360 degrees, so the code adds to the top phase bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_out_reg <= 16'h0000;
    end else if (ce) begin
      phase_out_reg <= osc_en_reg ? (acc_next[47:32] + phase_code) : 16'h0000; // RULE5 RULE8
    end
  end

endmodule
`default_nettype wire

// *** main_nco_consts.svh ***
// register map, field positions, reset values and bus answers of the main oscillator settings
//
// Behaviour
// RULE1 - fraction mode off: frequency is sample rate times 48-bit tuning word over 2^48.
// RULE2 - fraction mode on: tuning word plus numerator over denominator, all over 2^48.
// RULE3 - tuning word bytes ascend with address; bits 47..40 live at the top byte.
// RULE4 - phase shift is 16-bit two's complement, low byte first, high byte next.
// RULE5 - output phase moves by 180 degrees times the signed code over 2^15.
// RULE6 - denominator low byte has its own register, used only in fraction mode.
// RULE7 - software raises load request 0 to 1; device loads the word, clears the bit.
// RULE8 - the oscillator runs only while its enable bit is 1.
// RULE9 - tuning bytes are staged in shadow storage until a load request moves them.
`ifndef MAIN_NCO_CONSTS_SVH
`define MAIN_NCO_CONSTS_SVH

// register indices; byte address is four times the index
`define TW_BYTE1_IDX 10'h1CC
`define TW_BYTE2_IDX 10'h1CD
`define TW_BYTE3_IDX 10'h1CE
`define TW_BYTE4_IDX 10'h1CF
`define TW_BYTE5_IDX 10'h1D0
`define PHASE_LOW_IDX 10'h1D1
`define PHASE_HIGH_IDX 10'h1D2
`define FRAC_DEN0_IDX 10'h1D3
`define CTRL_IDX 10'h1F0
`define STATUS_IDX 10'h1F1

// control register fields
`define CTRL_LOAD_BIT 0
`define CTRL_FRAC_BIT 1
`define CTRL_ENABLE_BIT 2

// status register fields
`define STATUS_PENDING_BIT 0
`define STATUS_RUN_BIT 1
`define STATUS_FRAC_BIT 2

// reset values
`define BYTE_RESET 8'h00
`define BIT_RESET 1'h0

// shadow storage shape
`define TW_SHADOW_BYTES 5

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** main_nco_pkg.sv ***
// types shared by the main oscillator settings block
package main_nco_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef logic [47:0] tuning_word_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_FETCH,
    RD_MUX,
    RD_RESP
  } rd_state_t;

endpackage

// *** tuning_shadow_mem.sv ***
// shadow storage for the upper five tuning word bytes, registered read port
`timescale 1ns/1ps
`default_nettype none
`include "main_nco_consts.svh"

module tuning_shadow_mem (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire main_nco_pkg::reg_byte_t wr_data,
  input wire logic [2:0] rd_sel,
  output main_nco_pkg::reg_byte_t rd_data,
  output logic [39:0] shadow_word
);

  main_nco_pkg::reg_byte_t entry_reg [`TW_SHADOW_BYTES];

  // =======================================================
  // storage entries
  genvar i;
  generate
    for (i = 0; i < `TW_SHADOW_BYTES; i++) begin : g_entry
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          entry_reg[i] <= `BYTE_RESET;
        end else if (ce && wr_en && (wr_sel == 3'(i))) begin
          entry_reg[i] <= wr_data; // RULE9
        end
      end
      assign shadow_word[8*i +: 8] = entry_reg[i]; // RULE3
    end
  endgenerate

  // =======================================================
  // registered read port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= `BYTE_RESET;
    end else if (ce) begin
      rd_data <= (rd_sel < 3'h5) ? entry_reg[rd_sel] : `BYTE_RESET;
    end
  end

endmodule
`default_nettype wire

// *** main_nco_properties.sv ***
// concurrent assertions on the ports of the main oscillator settings block
`timescale 1ns/1ps
`default_nettype none
module main_nco_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic tuning_load_request,
  input wire logic main_oscillator_enable,
  input wire logic [15:0] oscillator_phase
);
  // ==========
  // bus handshakes
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence wr_take_s;
    ce && awvalid && awready && wvalid && wready;
  endsequence
  sequence wr_answer_s;
    !bvalid ##1 bvalid;
  endsequence
  sequence rd_take_s;
    ce && arvalid && arready;
  endsequence
  sequence rd_answer_s;
    !rvalid [*2] ##1 rvalid;
  endsequence
  AST_WR_LATENCY: assert property (wr_take_s |=> wr_answer_s)
    else $error("write answer late or early");
  AST_RD_LATENCY: assert property (rd_take_s |=> rd_answer_s)
    else $error("read answer late or early");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before taken");
  AST_B_REFUSE: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  AST_R_REFUSE: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  AST_CE_FREEZE: assert property (!ce |-> (!awready && !wready && !arready) ##1 $stable(oscillator_phase))
    else $error("state moved while clock enable low");
  AST_RESET_CLEAR: assert property ($fell(rst) |-> !bvalid && !rvalid && !tuning_load_request
    && !main_oscillator_enable && oscillator_phase == 16'h0000)
    else $error("outputs not cleared by reset");
  // ==========
  // oscillator controls
  AST_LOAD_PULSE: assert property ($rose(tuning_load_request) |=> !tuning_load_request)
    else $error("load request not cleared");
  AST_LOAD_CAUSE: assert property ($rose(tuning_load_request) |-> $rose(bvalid))
    else $error("load request without write");
  AST_OSC_OFF: assert property ((!main_oscillator_enable && ce) [*2] |-> oscillator_phase == 16'h0000)
    else $error("oscillator runs while disabled");
endmodule
bind main_nco_tuning_phase_regs main_nco_properties props_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .tuning_load_request(tuning_load_request), .main_oscillator_enable(main_oscillator_enable),
  .oscillator_phase(oscillator_phase));
`default_nettype wire

// *** main_nco_tuning_phase_regs_test.sv ***
// self-checking bench for the main oscillator settings block
`timescale 1ns/1ps
`default_nettype none
`include "main_nco_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module main_nco_tuning_phase_regs_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] low_byte = 8'h00;
  logic [47:0] numer = 48'h000000000000;
  logic [47:8] den_up = 40'h0000000000;
  logic awready, wready, bvalid, arready, rvalid, load_req, frac_en, osc_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] phase, prev;
  logic [9:0] idx_tab [8] = '{`TW_BYTE1_IDX, `TW_BYTE2_IDX, `TW_BYTE3_IDX, `TW_BYTE4_IDX,
    `TW_BYTE5_IDX, `PHASE_LOW_IDX, `PHASE_HIGH_IDX, `FRAC_DEN0_IDX};
  int fail_count = 0, n_compared = 0, pulses = 0, i;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (load_req === 1'b1) pulses++;
  main_nco_tuning_phase_regs uut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tuning_word_low_byte(low_byte), .fraction_numerator(numer), .fraction_denominator_upper(den_up),
    .tuning_load_request(load_req), .fraction_mode_enable(frac_en), .main_oscillator_enable(osc_en),
    .oscillator_phase(phase));
  // ==========
  // tasks
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic give_up(input int n);
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= s;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    give_up(n);
    `CHK(bresp, er)
  endtask
  task automatic axi_rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    give_up(n);
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask
  task automatic steps(input logic [15:0] e);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    prev = phase;
    repeat (4) begin
      @(negedge sys_clk);
      `CHK(phase - prev, e)
      prev = phase;
    end
    @(posedge sys_clk);
  endtask
  // ==========
  // main sequence
  initial begin
    do_reset();
    for (i = 0; i < 8; i++) axi_rd(idx_tab[i], 32'h00000000, `RESP_OKAY);
    for (i = 0; i < 8; i++) axi_wr(idx_tab[i], 8'hA0 + 8'(i), 4'h1, `RESP_OKAY);
    for (i = 0; i < 8; i++) axi_rd(idx_tab[i], {24'h000000, 8'hA0 + 8'(i)}, `RESP_OKAY);
    axi_wr(`PHASE_LOW_IDX, 8'h55, 4'h0, `RESP_OKAY);
    axi_rd(`PHASE_LOW_IDX, 32'h000000A5, `RESP_OKAY);
    axi_wr(10'h1E0, 8'h12, 4'h1, `RESP_SLVERR);
    axi_rd(10'h1E0, 32'h00000000, `RESP_SLVERR);
    axi_wr(`STATUS_IDX, 8'h07, 4'h1, `RESP_OKAY);
    axi_rd(`STATUS_IDX, 32'h00000000, `RESP_OKAY);
    do_reset();
    axi_wr(`CTRL_IDX, 8'h04, 4'h1, `RESP_OKAY);
    axi_wr(`PHASE_HIGH_IDX, 8'h80, 4'h1, `RESP_OKAY);
    axi_wr(`TW_BYTE4_IDX, 8'h01, 4'h1, `RESP_OKAY);
    axi_wr(`TW_BYTE5_IDX, 8'h02, 4'h1, `RESP_OKAY);
    steps(16'h0000);
    `CHK(phase, 16'h8000)
    axi_wr(`PHASE_HIGH_IDX, 8'h00, 4'h1, `RESP_OKAY);
    axi_rd(`STATUS_IDX, 32'h00000002, `RESP_OKAY);
    axi_wr(`CTRL_IDX, 8'h05, 4'h1, `RESP_OKAY);
    axi_rd(`CTRL_IDX, 32'h00000004, `RESP_OKAY);
    steps(16'h0201);
    for (i = 0; i < 3; i++) axi_wr(idx_tab[i], 8'hFF, 4'h1, `RESP_OKAY);
    axi_wr(`FRAC_DEN0_IDX, 8'h01, 4'h1, `RESP_OKAY);
    low_byte <= 8'hFF;
    numer <= 48'h000000000001;
    axi_wr(`CTRL_IDX, 8'h07, 4'h1, `RESP_OKAY);
    steps(16'h0202);
    axi_rd(`STATUS_IDX, 32'h00000006, `RESP_OKAY);
    `CHK({frac_en, osc_en}, 2'h3)
    axi_wr(`FRAC_DEN0_IDX, 8'h00, 4'h1, `RESP_OKAY);
    axi_rd(`STATUS_IDX, 32'h00000002, `RESP_OKAY);
    ce <= 1'b0;
    @(negedge sys_clk);
    prev = phase;
    repeat (3) @(negedge sys_clk);
    `CHK(phase, prev)
    @(posedge sys_clk);
    ce <= 1'b1;
    axi_wr(`CTRL_IDX, 8'h00, 4'h1, `RESP_OKAY);
    repeat (2) @(negedge sys_clk);
    `CHK(phase, 16'h0000)
    axi_rd(`STATUS_IDX, 32'h00000000, `RESP_OKAY);
    `CHK({frac_en, osc_en}, 2'h0)
    `CHK(pulses, 2)
    stop_test();
  end
endmodule
`default_nettype wire
